//--- rtl/ipc_config_unit.sv
// Plug and play configuration unit: register load, key detection, state machine
`default_nettype none

// How it works
// - Valid EEPROM fills resource registers after reset
// - EEPROM activation flag makes device active
// - Checksum error: discard, defaults, relocatable mode
// - Standard key still accepted after EEPROM activation
// - Legacy lock: vendor key only, standard ignored
// - No EEPROM: defaults into all registers
// - IRQ/DMA default 03, IRQ type 02
// - Relocatable mode waits for key after reset
// - Key bytes written to address port 0x0279
// - Only low data byte used
// - Recognise standard and vendor key sequences
// - Mismatch such as two zero writes resets LFSR
// - Complete key moves WAIT FOR KEY to SLEEP
// - Control 0x05 resets device, defaults, CARD_SELECT_NUMBER zero
// - WAKE matching CARD_SELECT_NUMBER zero enters ISOLATION
// - Set CARD_SELECT_NUMBER in ISOLATION enters CONFIG
// - I/O base from registers io_base_high and io_base_low
// - Active device answers at programmed base
// - Control bit1 returns to WAIT FOR KEY
// - Legacy lock is bit 6 of vendor_config
// - Lock clear: standard if EEPROM good, else vendor
// - Strap low at reset means no EEPROM
//
// Load sequence
//   Strap settles four edges
//   Strap high: wait for done
//   Strap low: defaults, reloc
//   Bad sum: defaults, reloc
//   Good sum: values kept
//
// States
//   WAIT FOR KEY: key only
//   SLEEP: commands only
//   ISOLATION: set card number
//   CONFIG: resources open
//
// Key checkers
//   Two run side by side
//   Each holds next byte
//   Wrong byte restarts it
//   32 bytes in a row unlock
//   Lock and load pick one
//
// Port map
//   Index at address port
//   Data at write port
//   Reads at read port
//   32-byte resource window
//
// Hazards
//   Strobes synced twice
//   Address settles first
//   One idle cycle needed
//   Undefined bits load 0
//
// Limits
//   One card, no isolation
//   Loader is outside
//   No upper data byte
//   No range checking
//   Most regs stored only
//
// Reset
//   Synchronous, active high
//   Registers to defaults
//   Checkers restart
//   Load restarts at strap

module ipc_config_unit (
  input wire logic ref_clk,                          // Unit clock, 10 MHz
  input wire logic rst,                              // Synchronous reset, active high
  input wire ipc_pkg::ipc_isa_in_t isa_in,           // ISA strobes, address, low data byte
  input wire ipc_pkg::ipc_ee_wr_t ee_wr,             // Register write from EEPROM loader
  input wire logic ee_done,                          // EEPROM load finished, pulse
  input wire logic ee_csum_ok,                       // EEPROM checksum good, with ee_done
  input wire logic ee_active,                        // EEPROM activation flag, with ee_done
  input wire logic eeprom_present_strap,             // Strap pin, high when EEPROM fitted
  output logic [7:0] isa_data_out,                   // Read data toward ISA bus
  output logic isa_data_oe,                          // Drive enable for read data
  output logic io_select,                            // Cycle hits device I/O window
  output logic [15:0] io_base_value,                 // Programmed I/O base address
  output logic config_active_flag,                   // Device active
  output logic [15:0] isa_config_status_reg_two,     // Status word with activation flag
  output logic sw_reloc_mode,                        // Software relocatable mode
  output logic private_bus_share,                    // Private bus pins shared
  output logic load_done,                            // Register load complete
  output ipc_pkg::ipc_cfg_state_t cfg_state          // Configuration state
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Slot lookup: bit 5 flags a hit, bits 4:0 give the slot
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    logic [5:0] r;
    r = 6'h00;
    for (int i = 0; i < ipc_pkg::IPC_NUM_SLOTS; i++) begin
      if (ipc_pkg::IPC_REG_IDX[i] == idx) begin
        r = {1'b1, i[4:0]};
      end
    end
    return r;
  endfunction

  // Next key byte
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[1] ^ v[0], v[7:1]};
  endfunction

  // State fields
  //   isa_s1, isa_s2: bus sync
  //   iow_d: strobe delayed
  //   strap_s1, strap_s2: sync
  //   ld, ld_cnt: loader
  //   ee_ok: checksum good
  //   sw_reloc: reloc mode
  //   cfg: config state
  //   idx: register index
  //   lfsr, cnt: checkers
  //   regs: registers by slot
  //   dout, dout_oe: read
  //   io_sel: window hit

  ipc_pkg::ipc_state_t s_ff;
  ipc_pkg::ipc_state_t nxt_s;

  // Bus decode
  //   wr_ev: write seen
  //   addr, wdat: bus values
  //   wslot, rslot: index slot
  //   rd_port: read port
  //   base: resource base
  //   legacy: lock bit
  //   key_ok: key allowed
  //   eslot: loader slot

  logic wr_ev;
  logic [15:0] addr;
  logic [7:0] wdat;
  logic [5:0] wslot;
  logic [5:0] rslot;
  logic [15:0] rd_port;
  logic [15:0] base;
  logic legacy;
  logic [1:0] key_ok;
  logic [5:0] eslot;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    nxt_s = s_ff;
    nxt_s.isa_s1 = isa_in;
    nxt_s.isa_s2 = s_ff.isa_s1;
    nxt_s.iow_d = s_ff.isa_s2.iow_n;
    nxt_s.strap_s1 = eeprom_present_strap;
    nxt_s.strap_s2 = s_ff.strap_s1;

    eslot = slot_of(ee_wr.idx);
    wr_ev = !s_ff.isa_s2.iow_n && s_ff.iow_d;
    addr = s_ff.isa_s2.addr;
    wdat = s_ff.isa_s2.data;
    wslot = slot_of(s_ff.idx);
    rslot = slot_of(s_ff.idx);
    rd_port = {6'h00, s_ff.regs[ipc_pkg::IPC_SLOT_RD_PORT], 2'h3};
    base = {s_ff.regs[ipc_pkg::IPC_SLOT_BASE_HI], s_ff.regs[ipc_pkg::IPC_SLOT_BASE_LO]};
    legacy = s_ff.regs[ipc_pkg::IPC_SLOT_VENDOR][ipc_pkg::IPC_LEGACY_BIT];
    // Standard key only with good EEPROM and no lock; vendor key otherwise
    key_ok[0] = !legacy && s_ff.ee_ok;
    key_ok[1] = legacy || !s_ff.ee_ok;

    // ------------------------------------------------------------------------
    // Register load after reset
    // ------------------------------------------------------------------------
    // Strap read once
    // Loader writes while open
    // Unknown index dropped
    // Done closes the load
    case (s_ff.ld)
      ipc_pkg::LD_STRAP: begin
        nxt_s.ld_cnt = s_ff.ld_cnt + 2'h1;
        if (s_ff.ld_cnt == ipc_pkg::IPC_STRAP_SETTLE) begin
          if (s_ff.strap_s2) begin
            nxt_s.ld = ipc_pkg::LD_EEPROM;
          end else begin
            nxt_s.regs = ipc_pkg::IPC_REG_DEF;
            nxt_s.sw_reloc = 1'b1;
            nxt_s.ee_ok = 1'b0;
            nxt_s.ld = ipc_pkg::LD_DONE;
          end
        end
      end
      ipc_pkg::LD_EEPROM: begin
        if (ee_wr.wr && eslot[5]) begin
          nxt_s.regs[eslot[4:0]] = ee_wr.data;
        end
        if (ee_done) begin
          nxt_s.ld = ipc_pkg::LD_DONE;
          if (ee_csum_ok) begin
            nxt_s.ee_ok = 1'b1;
            nxt_s.regs[ipc_pkg::IPC_SLOT_ACT][ipc_pkg::IPC_ACT_BIT] = ee_active;
          end else begin
            nxt_s.regs = ipc_pkg::IPC_REG_DEF;
            nxt_s.sw_reloc = 1'b1;
            nxt_s.ee_ok = 1'b0;
          end
        end
      end
      ipc_pkg::LD_DONE: begin
        nxt_s.ld = ipc_pkg::LD_DONE;
      end
      default: begin
        nxt_s.ld = ipc_pkg::LD_STRAP;
      end
    endcase

    // ------------------------------------------------------------------------
    // Host writes
    // ------------------------------------------------------------------------
    if (s_ff.ld == ipc_pkg::LD_DONE && wr_ev && addr == ipc_pkg::IPC_ADDR_PORT) begin
      nxt_s.idx = wdat;
      // Index set in any state
      // Keys count in WAIT only
      if (s_ff.cfg == ipc_pkg::ST_WAIT_KEY) begin
        for (int k = 0; k < 2; k++) begin
          if (wdat == s_ff.lfsr[k]) begin
            nxt_s.lfsr[k] = lfsr_next(s_ff.lfsr[k]);
            nxt_s.cnt[k] = s_ff.cnt[k] + 5'h01;
            if (s_ff.cnt[k] == ipc_pkg::IPC_KEY_LAST && key_ok[k]) begin
              nxt_s.cfg = ipc_pkg::ST_SLEEP;
            end
          end else begin
            // Any mismatching byte, such as a zero write, restarts the check
            nxt_s.lfsr[k] = k[0] ? ipc_pkg::IPC_VEN_KEY_INIT : ipc_pkg::IPC_STD_KEY_INIT;
            nxt_s.cnt[k] = 5'h00;
          end
        end
        if (s_ff.cnt[0] == ipc_pkg::IPC_KEY_LAST || s_ff.cnt[1] == ipc_pkg::IPC_KEY_LAST) begin
          nxt_s.lfsr[0] = ipc_pkg::IPC_STD_KEY_INIT;
          nxt_s.lfsr[1] = ipc_pkg::IPC_VEN_KEY_INIT;
          nxt_s.cnt[0] = 5'h00;
          nxt_s.cnt[1] = 5'h00;
        end
      end
    end

    // Commands
    //   config_control bit0: defaults
    //   config_control bit2: card 0
    //   config_control bit1: WAIT
    //   wake_select: wake on match
    //   card_select_number: card, CONFIG
    //   read_port_setup: read port
    // Data port writes are ignored while waiting for the key
    if (s_ff.ld == ipc_pkg::LD_DONE && wr_ev && addr == ipc_pkg::IPC_WDATA_PORT &&
        s_ff.cfg != ipc_pkg::ST_WAIT_KEY) begin
      if (wslot == {1'b1, ipc_pkg::IPC_SLOT_CTRL}) begin
        if (wdat[ipc_pkg::IPC_CTRL_RESET_BIT]) begin
          for (int i = ipc_pkg::IPC_SLOT_RES_FIRST; i < ipc_pkg::IPC_NUM_SLOTS; i++) begin
            nxt_s.regs[i] = ipc_pkg::IPC_REG_DEF[i];
          end
        end
        if (wdat[ipc_pkg::IPC_CTRL_CSN_BIT]) begin
          nxt_s.regs[ipc_pkg::IPC_SLOT_CSN] = 8'h00;
        end
        if (wdat[ipc_pkg::IPC_CTRL_WFK_BIT]) begin
          nxt_s.cfg = ipc_pkg::ST_WAIT_KEY;
        end
      end else if (wslot == {1'b1, ipc_pkg::IPC_SLOT_WAKE}) begin
        if (wdat == s_ff.regs[ipc_pkg::IPC_SLOT_CSN]) begin
          nxt_s.cfg = wdat == 8'h00 ? ipc_pkg::ST_ISOLATE : ipc_pkg::ST_CONFIG;
        end else begin
          nxt_s.cfg = ipc_pkg::ST_SLEEP;
        end
      end else if (wslot == {1'b1, ipc_pkg::IPC_SLOT_CSN}) begin
        if (s_ff.cfg == ipc_pkg::ST_ISOLATE || s_ff.cfg == ipc_pkg::ST_CONFIG) begin
          nxt_s.regs[ipc_pkg::IPC_SLOT_CSN] = wdat;
          nxt_s.cfg = ipc_pkg::ST_CONFIG;
        end
      end else if (wslot == {1'b1, ipc_pkg::IPC_SLOT_RD_PORT}) begin
        if (s_ff.cfg == ipc_pkg::ST_ISOLATE || s_ff.cfg == ipc_pkg::ST_CONFIG) begin
          nxt_s.regs[ipc_pkg::IPC_SLOT_RD_PORT] = wdat;
        end
      end else if (wslot[5] && s_ff.cfg == ipc_pkg::ST_CONFIG) begin
        nxt_s.regs[wslot[4:0]] = wdat;
      end
    end

    // ------------------------------------------------------------------------
    // Host reads from the read data port, CONFIG only
    // ------------------------------------------------------------------------
    // Answer one cycle late
    // Enable drops a cycle late
    // Commands except card_select_number read as zero
    nxt_s.dout_oe = 1'b0;
    nxt_s.dout = 8'h00;
    if (s_ff.ld == ipc_pkg::LD_DONE && !s_ff.isa_s2.ior_n && addr == rd_port &&
        s_ff.cfg == ipc_pkg::ST_CONFIG) begin
      nxt_s.dout_oe = 1'b1;
      if (rslot[5] && rslot[4:0] > ipc_pkg::IPC_SLOT_WAKE) begin
        nxt_s.dout = s_ff.regs[rslot[4:0]];
      end
    end

    // Active device claims its 32-byte I/O window
    nxt_s.io_sel = s_ff.regs[ipc_pkg::IPC_SLOT_ACT][ipc_pkg::IPC_ACT_BIT] &&
                   (!s_ff.isa_s2.iow_n || !s_ff.isa_s2.ior_n) &&
                   addr[15:5] == base[15:5];
  end

  // ==========================================================================
  // State register
  // ==========================================================================
  // Reset parks both machines
  // Strap trusted once settled
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_ff <= '0;
      s_ff.regs <= ipc_pkg::IPC_REG_DEF;
      s_ff.lfsr[0] <= ipc_pkg::IPC_STD_KEY_INIT;
      s_ff.lfsr[1] <= ipc_pkg::IPC_VEN_KEY_INIT;
      s_ff.cfg <= ipc_pkg::ST_WAIT_KEY;
      s_ff.ld <= ipc_pkg::LD_STRAP;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Data from state register
  // Status: activation only
  // Share outside WAIT
  assign isa_data_out = s_ff.dout;
  assign isa_data_oe = s_ff.dout_oe;
  assign io_select = s_ff.io_sel;
  assign io_base_value = {s_ff.regs[ipc_pkg::IPC_SLOT_BASE_HI],
                          s_ff.regs[ipc_pkg::IPC_SLOT_BASE_LO]};
  assign config_active_flag = s_ff.regs[ipc_pkg::IPC_SLOT_ACT][ipc_pkg::IPC_ACT_BIT];
  always_comb begin
    isa_config_status_reg_two = 16'h0000;
    isa_config_status_reg_two[ipc_pkg::IPC_CSR2_ACT_BIT] = config_active_flag;
  end
  assign sw_reloc_mode = s_ff.sw_reloc;
  assign private_bus_share = s_ff.cfg != ipc_pkg::ST_WAIT_KEY;
  assign load_done = s_ff.ld == ipc_pkg::LD_DONE;
  assign cfg_state = s_ff.cfg;

endmodule

`default_nettype wire

//--- rtl/ipc_pkg.sv
// Constants, types and register map of the plug and play configuration unit
`default_nettype none

package ipc_pkg;

  // ==========================================================================
  // Configuration register map, one slot per register
  // ==========================================================================
  localparam int unsigned IPC_NUM_SLOTS = 23;

  // Register index of each slot, slot 22 first
  localparam logic [22:0][7:0] IPC_REG_IDX = {
    8'hf0, 8'h74, 8'h71, 8'h70, 8'h61, 8'h60, 8'h4c, 8'h4b,
    8'h4a, 8'h49, 8'h48, 8'h44, 8'h43, 8'h42, 8'h41, 8'h40,
    8'h31, 8'h30, 8'h07, 8'h06, 8'h03, 8'h02, 8'h00};

  // Default value of each slot, slot 22 first; undefined bits load as zero
  localparam logic [22:0][7:0] IPC_REG_DEF = {
    8'h00, 8'h03, 8'h02, 8'h03, 8'h00, 8'h02, 8'h00, 8'h00,
    8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  localparam logic [4:0] IPC_SLOT_RD_PORT = 5'h00;
  localparam logic [4:0] IPC_SLOT_CTRL = 5'h01;
  localparam logic [4:0] IPC_SLOT_WAKE = 5'h02;
  localparam logic [4:0] IPC_SLOT_CSN = 5'h03;
  localparam logic [4:0] IPC_SLOT_ACT = 5'h05;
  localparam logic [4:0] IPC_SLOT_RES_FIRST = 5'h05;
  localparam logic [4:0] IPC_SLOT_BASE_HI = 5'h11;
  localparam logic [4:0] IPC_SLOT_BASE_LO = 5'h12;
  localparam logic [4:0] IPC_SLOT_VENDOR = 5'h16;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned IPC_CTRL_RESET_BIT = 0;
  localparam int unsigned IPC_CTRL_WFK_BIT = 1;
  localparam int unsigned IPC_CTRL_CSN_BIT = 2;
  localparam int unsigned IPC_ACT_BIT = 0;
  localparam int unsigned IPC_LEGACY_BIT = 6;
  localparam int unsigned IPC_CSR2_ACT_BIT = 9;

  // ==========================================================================
  // Host ports and key sequences
  // ==========================================================================
  localparam logic [15:0] IPC_ADDR_PORT = 16'h0279;
  localparam logic [15:0] IPC_WDATA_PORT = 16'h0a79;
  localparam logic [7:0] IPC_STD_KEY_INIT = 8'h6a;
  localparam logic [7:0] IPC_VEN_KEY_INIT = 8'h6b;
  localparam logic [4:0] IPC_KEY_LAST = 5'h1f;
  localparam logic [1:0] IPC_STRAP_SETTLE = 2'h3;
  localparam logic [10:0] IPC_IO_WINDOW_BITS = 11'h7ff;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {ST_WAIT_KEY, ST_SLEEP, ST_ISOLATE, ST_CONFIG} ipc_cfg_state_t;
  typedef enum logic [1:0] {LD_STRAP, LD_EEPROM, LD_DONE} ipc_load_state_t;

  typedef struct packed {
    logic iow_n;
    logic ior_n;
    logic [15:0] addr;
    logic [7:0] data;
  } ipc_isa_in_t;

  typedef struct packed {
    logic wr;
    logic [7:0] idx;
    logic [7:0] data;
  } ipc_ee_wr_t;

  typedef struct packed {
    ipc_isa_in_t isa_s1;
    ipc_isa_in_t isa_s2;
    logic iow_d;
    logic strap_s1;
    logic strap_s2;
    ipc_load_state_t ld;
    logic [1:0] ld_cnt;
    logic ee_ok;
    logic sw_reloc;
    ipc_cfg_state_t cfg;
    logic [7:0] idx;
    logic [1:0][7:0] lfsr;
    logic [1:0][4:0] cnt;
    logic [22:0][7:0] regs;
    logic [7:0] dout;
    logic dout_oe;
    logic io_sel;
  } ipc_state_t;

endpackage

`default_nettype wire

//--- sim/ipc_config_unit_assertions.sv
// Port checker for the plug and play configuration unit
`default_nettype none

module ipc_config_unit_checker (
  input wire logic ref_clk,                          // Unit clock
  input wire logic rst,                              // Synchronous reset
  input wire ipc_pkg::ipc_isa_in_t isa_in,           // ISA inputs
  input wire ipc_pkg::ipc_cfg_state_t cfg_state,     // Configuration state
  input wire logic private_bus_share,                // Private bus shared
  input wire logic [15:0] isa_config_status_reg_two, // Status word
  input wire logic config_active_flag,               // Device active
  input wire logic sw_reloc_mode,                    // Relocatable mode
  input wire logic load_done,                        // Load finished
  input wire logic isa_data_oe,                      // Read drive enable
  input wire logic io_select,                        // I/O window hit
  input wire logic [15:0] io_base_value              // I/O base
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_share_by_state: assert property (private_bus_share == (cfg_state != ipc_pkg::ST_WAIT_KEY))
    else $error("bus share disagrees with state");
  a_status_bit_nine: assert property (isa_config_status_reg_two == {6'h00, config_active_flag, 9'h000})
    else $error("status word wrong");
  a_reset_init: assert property ($fell(rst) |-> cfg_state == ipc_pkg::ST_WAIT_KEY && io_base_value == 16'h0200 && !load_done)
    else $error("state after reset wrong");
  a_reloc_sticky: assert property (sw_reloc_mode |=> sw_reloc_mode)
    else $error("relocatable mode dropped");
  a_idle_before_load: assert property (!load_done |-> cfg_state == ipc_pkg::ST_WAIT_KEY && !isa_data_oe && !io_select)
    else $error("activity before load");
  a_read_in_config: assert property (isa_data_oe |-> $past(cfg_state) == ipc_pkg::ST_CONFIG)
    else $error("read driven outside config");
  a_select_when_active: assert property (io_select |-> config_active_flag || $past(config_active_flag))
    else $error("select while inactive");
  a_key_to_sleep: assert property ($past(cfg_state) == ipc_pkg::ST_WAIT_KEY && !$past(rst) |-> cfg_state inside {ipc_pkg::ST_WAIT_KEY, ipc_pkg::ST_SLEEP})
    else $error("left wait for key wrongly");
  a_config_entry: assert property (cfg_state == ipc_pkg::ST_CONFIG && $past(cfg_state) != ipc_pkg::ST_CONFIG |-> $past(cfg_state) != ipc_pkg::ST_WAIT_KEY)
    else $error("config entered from wait for key");
  a_change_by_write: assert property ($changed(cfg_state) && !$past(rst) |-> $past(isa_in.iow_n, 2) == 1'b0 || $past(isa_in.iow_n, 3) == 1'b0)
    else $error("state changed without write");
endmodule

`default_nettype wire

//--- sim/ipc_config_unit_tb.sv
// Self-checking testbench of the plug and play configuration unit
`default_nettype none

module ipc_config_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {logic [7:0] idx; logic we; logic [7:0] wd; logic [7:0] exp;} ipc_row_t;
  localparam logic [15:0] S_WAIT = 16'(ipc_pkg::ST_WAIT_KEY);
  localparam logic [15:0] S_SLEEP = 16'(ipc_pkg::ST_SLEEP);
  localparam logic [15:0] S_ISO = 16'(ipc_pkg::ST_ISOLATE);
  localparam logic [15:0] S_CFG = 16'(ipc_pkg::ST_CONFIG);
  logic ref_clk, rst, ee_done, ee_csum_ok, ee_active, strap, io_select, config_active_flag;
  logic sw_reloc_mode, private_bus_share, load_done, isa_data_oe, seen, ok, lk;
  logic [7:0] isa_data_out, rdv;
  logic [15:0] io_base_value, isa_config_status_reg_two;
  ipc_pkg::ipc_isa_in_t isa_in;
  ipc_pkg::ipc_ee_wr_t ee_wr;
  ipc_pkg::ipc_cfg_state_t cfg_state;
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;
  ipc_row_t rows [9] = '{'{8'h70, 1'b0, 8'h00, 8'h03}, '{8'h71, 1'b0, 8'h00, 8'h02},
    '{8'h74, 1'b0, 8'h00, 8'h03}, '{8'h42, 1'b0, 8'h00, 8'h02}, '{8'h4a, 1'b0, 8'h00, 8'h02},
    '{8'h60, 1'b1, 8'h03, 8'h03}, '{8'h61, 1'b1, 8'h40, 8'h40}, '{8'h30, 1'b1, 8'h01, 8'h01},
    '{8'h55, 1'b1, 8'hab, 8'h00}};

  ipc_config_unit dut_u (.ref_clk(ref_clk), .rst(rst), .isa_in(isa_in), .ee_wr(ee_wr),
    .ee_done(ee_done), .ee_csum_ok(ee_csum_ok), .ee_active(ee_active),
    .eeprom_present_strap(strap), .isa_data_out(isa_data_out), .isa_data_oe(isa_data_oe),
    .io_select(io_select), .io_base_value(io_base_value), .config_active_flag(config_active_flag),
    .isa_config_status_reg_two(isa_config_status_reg_two), .sw_reloc_mode(sw_reloc_mode),
    .private_bus_share(private_bus_share), .load_done(load_done), .cfg_state(cfg_state));
  ipc_host_model hm (.ref_clk(ref_clk), .rd_data(isa_data_out), .rd_oe(isa_data_oe), .isa_in(isa_in));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cw(input logic [7:0] i, input logic [7:0] d);
    hm.wr(16'h0279, i);
    hm.wr(16'h0a79, d);
  endtask

  task automatic send_key(input logic [7:0] seed);
    logic [7:0] k;
    hm.wr(16'h0279, 8'h00);
    hm.wr(16'h0279, 8'h00);
    repeat (2) begin
      k = seed;
      repeat (32) begin
        hm.wr(16'h0279, k);
        k = {k[1] ^ k[0], k[7:1]};
      end
    end
  endtask

  task automatic boot(input logic s);
    rst = 1'b1;
    strap = s;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    repeat (8) @(negedge ref_clk);
  endtask

  task automatic ee_put(input logic [7:0] i, input logic [7:0] d);
    ee_wr = '{wr: 1'b1, idx: i, data: d};
    @(negedge ref_clk);
    ee_wr.wr = 1'b0;
  endtask

  // ==========================================================================
  // Sequence
  // ==========================================================================
  initial begin
    {ee_done, ee_csum_ok, ee_active} = 3'b000;
    ee_wr = '0;
    boot(1'b0);
    chk({load_done, sw_reloc_mode, private_bus_share}, 16'h0006);
    chk(io_base_value, 16'h0200);
    send_key(8'h6a);
    chk(cfg_state, S_WAIT);
    send_key(8'h6b);
    chk(cfg_state, S_SLEEP);
    cw(8'h02, 8'h05);
    cw(8'h03, 8'h00);
    chk(cfg_state, S_ISO);
    cw(8'h06, 8'h01);
    chk(cfg_state, S_CFG);
    cw(8'h00, 8'h80);
    foreach (rows[i]) begin
      if (rows[i].we) cw(rows[i].idx, rows[i].wd);
      hm.wr(16'h0279, rows[i].idx);
      hm.rd(16'h0203, rdv);
      chk(rdv, rows[i].exp);
    end
    chk(io_base_value, 16'h0340);
    chk(isa_config_status_reg_two, 16'h0200);
    for (int j = 0; j < 2; j++) begin
      seen = 1'b0;
      fork
        hm.wr(j == 0 ? 16'h0352 : 16'h0362, 8'h11);
        repeat (9) @(posedge ref_clk) seen = seen | io_select;
      join
      chk(seen, j == 0);
    end
    cw(8'h02, 8'h02);
    chk({private_bus_share, cfg_state}, S_WAIT);
    send_key(8'h6b);
    cw(8'h60, 8'h77);
    chk(io_base_value, 16'h0340);
    cw(8'h03, 8'h01);
    chk(cfg_state, S_CFG);
    cw(8'h02, 8'h05);
    chk(io_base_value, 16'h0200);
    chk(16'(config_active_flag), 16'h0000);
    for (int i = 0; i < 3; i++) begin
      ok = (i != 2);
      lk = (i != 0);
      boot(1'b1);
      ee_put(8'h60, 8'h02);
      ee_put(8'h61, 8'h80);
      ee_put(8'hf0, {1'b0, lk, 6'h00});
      {ee_done, ee_csum_ok, ee_active} = {1'b1, ok, 1'b1};
      @(negedge ref_clk);
      ee_done = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk({sw_reloc_mode, config_active_flag}, {14'h0, !ok, ok});
      chk(io_base_value, ok ? 16'h0280 : 16'h0200);
      send_key(8'h6a);
      chk(cfg_state, (ok && !lk) ? S_SLEEP : S_WAIT);
      cw(8'h02, 8'h02);
      send_key(8'h6b);
      chk(cfg_state, (ok && !lk) ? S_WAIT : S_SLEEP);
    end
    complete_run();
  end
endmodule

bind ipc_config_unit ipc_config_unit_checker chk_u (.ref_clk, .rst, .isa_in, .cfg_state,
  .private_bus_share, .isa_config_status_reg_two, .config_active_flag, .sw_reloc_mode,
  .load_done, .isa_data_oe, .io_select, .io_base_value);

`default_nettype wire

//--- sim/ipc_host_model.sv
// Host model: configuration software issuing ISA I/O writes and reads
`default_nettype none

module ipc_host_model (
  input wire logic ref_clk,            // Bus clock
  input wire logic [7:0] rd_data,      // Read data from the device
  input wire logic rd_oe,              // Device drives read data
  output ipc_pkg::ipc_isa_in_t isa_in  // Strobes, address, low data byte
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Bus cycles
  // ==========================================================================
  initial isa_in = '{iow_n: 1'b1, ior_n: 1'b1, addr: 16'hffff, data: 8'hff};

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    isa_in.addr = a;
    isa_in.data = d;
    @(negedge ref_clk);
    isa_in.iow_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    isa_in.iow_n = 1'b1;
    // Released lines show the inverse, never the stale value
    isa_in.addr = ~a;
    isa_in.data = ~d;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    isa_in.addr = a;
    @(negedge ref_clk);
    isa_in.ior_n = 1'b0;
    repeat (6) @(posedge ref_clk);
    d = (rd_oe === 1'b1) ? rd_data : 8'hxx;
    @(negedge ref_clk);
    isa_in.ior_n = 1'b1;
    isa_in.addr = ~a;
    repeat (3) @(negedge ref_clk);
  endtask
endmodule

`default_nettype wire
